// >>> verilog/conv_ctl_defines.svh
/*
 * Offsets, field positions, reset values and cycle counts of the
 * converter control block. Definitions only; include by bare name.
 */
`ifndef CONV_CTL_DEFINES_SVH
`define CONV_CTL_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS 100
`define TRIM_REQ_CYCLES 4'hA
`define DELAY_SHORT_CYCLES 32'h0100_0000
`define DELAY_LONG_CYCLES 32'h4000_0000
`define TRIM_RUN_CYCLES 16'h0400
`define DIV_RISE 3'h4
`define DIV_FALL 3'h0
`define LAT_NEAR 7
`define LAT_FAR 8

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_STATUS 8'h00
`define ADDR_MASK 8'h04
`define ADDR_STATE 8'h08
`define EV_TRIM_DONE 0
`define EV_PD_ENTER 1
`define EV_RANGE 2
`define EV_REQ_IGNORED 3
`define EV_WIDTH 4
`define STATUS_RESET 4'h0
`define MASK_RESET 4'h0

// ****************************************************************
// Code mapping
// ****************************************************************
`define CODE_OFFSET 10'h080
`define CODE_MAX 10'h0FF

`endif

// >>> verilog/conv_ctl_pkg.sv
/*
 * Types shared by the converter control block and its delay line.
 * Assumes conv_ctl_defines.svh is available on the include path.
 */
`include "conv_ctl_defines.svh"

package conv_ctl_pkg;

    // One-hot control states
    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_RUN = 4'h2,
        ST_TRIM = 4'h4,
        ST_DOWN = 4'h8
    } state_type;

    // Range flag beside an offset-binary code
    typedef struct packed {
        logic range;
        logic [7:0] code;
    } word_type;

endpackage : conv_ctl_pkg

// >>> verilog/sample_delay.sv
/*
 * Sample delay line: eight words deep, advancing once per sample enable,
 * with registered taps at seven and eight sample periods.
 * Assumes shift_en is a one-cycle pulse on clk.
 */
`timescale 1ns/10ps
`include "conv_ctl_defines.svh"

module sample_delay
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic shift_en,
    input conv_ctl_pkg::word_type din,
    // Registered taps
    output conv_ctl_pkg::word_type tap_near,
    output conv_ctl_pkg::word_type tap_far
);

    typedef struct packed {
        conv_ctl_pkg::word_type [7:0] mem;
        conv_ctl_pkg::word_type near;
        conv_ctl_pkg::word_type far;
    } line_type;

    line_type q;
    line_type d;

    // Shift and read taps from the old contents, so each tap adds its own cycle
    always_comb
    begin
        d = q;
        if (shift_en)
        begin
            d.near = q.mem[`LAT_NEAR - 1];
            d.far = q.mem[`LAT_FAR - 1];
            d.mem = {q.mem[6:0], din};
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign tap_near = q.near;
    assign tap_far = q.far;

endmodule : sample_delay

// >>> verilog/conv_ctl.sv
/*
 * Control and status logic of an 8-bit converter: power-down, power-on
 * and commanded trim sequencing, offset-binary coding with range flag,
 * two interleaved output buses launched against a forwarded clock,
 * and a small register port with a masked interrupt.
 * Assumes control pins are asynchronous to clk and sample_in is on clk.
 */
// Chosen here: the address map and the strobed register port.
// Function
// - Range flag high for clipped output words
// - Pin low runs, pin high powers down
// - Powered down: all outputs high impedance (code keeps driving every output and only lowers output_enable)
// - Power-down waits for running trim to finish
// - Power-on delay frozen while power-down high
// - Trim requests ignored and dropped when down
// - Launch edge select picks clock edge
// - Trim active output high while trimming
// - Codes are offset binary, zero at midscale
// - Request: ten cycles low, ten high
// - Power-on delay 2^24 or 2^30 cycles
// - Buses carry samples 7 and 8 late
`timescale 1ns/10ps
`include "conv_ctl_defines.svh"

module conv_ctl
#(
    parameter int unsigned DELAY_SHORT = `DELAY_SHORT_CYCLES,
    parameter int unsigned DELAY_LONG = `DELAY_LONG_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control pins
    input wire logic power_down_pin,
    input wire logic trim_request_pin,
    input wire logic launch_edge_select,
    input wire logic trim_delay_select,
    // Converter core sample, two's complement, on clk
    input wire logic [9:0] sample_in,
    // Output link
    output logic forwarded_data_clock,
    output logic [7:0] bus_near_data,
    output logic bus_near_range,
    output logic [7:0] bus_far_data,
    output logic bus_far_range,
    output logic output_enable,
    output logic trim_active,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        conv_ctl_pkg::state_type state;
        logic pd_s1;
        logic pd_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic edge_s1;
        logic edge_s2;
        logic dly_s1;
        logic dly_s2;
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic [30:0] delay_cnt;
        logic [15:0] trim_cnt;
        logic [2:0] div;
        logic fclk;
        logic [7:0] near_data;
        logic near_range;
        logic [7:0] far_data;
        logic far_range;
        logic oe;
        logic trim;
        logic [`EV_WIDTH-1:0] status;
        logic [`EV_WIDTH-1:0] mask;
        logic irq;
        logic [31:0] rdata;
    } ctl_type;

    ctl_type q;
    ctl_type d;

    conv_ctl_pkg::word_type tap_near;
    conv_ctl_pkg::word_type tap_far;
    conv_ctl_pkg::word_type coded;
    logic sample_en;
    logic launch;
    logic req_cmd;
    logic delay_done;
    logic [`EV_WIDTH-1:0] events;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Offset binary: -128 maps to 00, +127 to FF; clip and flag beyond
    function automatic conv_ctl_pkg::word_type encode(input logic [9:0] s);
        logic [9:0] biased;
        conv_ctl_pkg::word_type w;
        biased = s + `CODE_OFFSET;
        w.range = 1'b0;
        w.code = biased[7:0];
        if ($signed(s) < -10'sd128)
        begin
            w.range = 1'b1;
            w.code = 8'h00;
        end
        else if ($signed(s) > 10'sd127)
        begin
            w.range = 1'b1;
            w.code = 8'hFF;
        end
        return w;
    endfunction : encode

    // Power-on delay target from the synchronised select pin
    function automatic logic [30:0] delay_target(input logic long_sel);
        return long_sel ? 31'(DELAY_LONG) : 31'(DELAY_SHORT);
    endfunction : delay_target

    // Sample clock is clk / 4; the forwarded clock spans two samples
    assign sample_en = (q.div[1:0] == 2'h3) && !q.state[3];
    assign coded = encode(sample_in);
    assign req_cmd = q.req_s2 && (q.low_cnt == `TRIM_REQ_CYCLES)
        && (q.high_cnt == `TRIM_REQ_CYCLES - 4'h1);
    assign delay_done = (q.delay_cnt >= delay_target(q.dly_s2) - 31'h1);

    // ****************************************************************
    // Delay line
    // ****************************************************************
    sample_delay u_delay
    (
        .clk(clk),
        .rst(rst),
        .shift_en(sample_en),
        .din(coded),
        .tap_near(tap_near),
        .tap_far(tap_far)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        events = '0;
        launch = 1'b0;

        // Two-flop synchronisers; the first stage is never read
        d.pd_s1 = power_down_pin;
        d.pd_s2 = q.pd_s1;
        d.req_s1 = trim_request_pin;
        d.req_s2 = q.req_s1;
        d.req_s3 = q.req_s2;
        d.edge_s1 = launch_edge_select;
        d.edge_s2 = q.edge_s1;
        d.dly_s1 = trim_delay_select;
        d.dly_s2 = q.dly_s1;

        // Request filter: count a low run, then a high run, noise restarts it
        if (q.state == conv_ctl_pkg::ST_DOWN || (q.state == conv_ctl_pkg::ST_WAIT && q.pd_s2)
            || (q.req_s2 && (q.low_cnt != `TRIM_REQ_CYCLES || req_cmd)))
        begin
            d.low_cnt = 4'h0;
            d.high_cnt = 4'h0;
        end
        else if (!q.req_s2)
        begin
            d.high_cnt = 4'h0;
            if (q.low_cnt != `TRIM_REQ_CYCLES)
                d.low_cnt = q.low_cnt + 4'h1;
        end
        else
        begin
            d.high_cnt = q.high_cnt + 4'h1;
        end

        // A request rising while powered down is dropped and noted; the extra
        // stage finds the edge without reading the first synchroniser flop
        if (q.state == conv_ctl_pkg::ST_DOWN && q.req_s2 && !q.req_s3)
            events[`EV_REQ_IGNORED] = 1'b1;

        // Sequencer; the trim counter rests at zero outside a trim
        d.trim_cnt = 16'h0;
        case (q.state)
            conv_ctl_pkg::ST_WAIT:
            begin
                if (!q.pd_s2)
                    d.delay_cnt = q.delay_cnt + 31'h1;
                if (req_cmd || (!q.pd_s2 && delay_done))
                    d.state = conv_ctl_pkg::ST_TRIM;
            end
            conv_ctl_pkg::ST_RUN:
            begin
                if (q.pd_s2)
                begin
                    d.state = conv_ctl_pkg::ST_DOWN;
                    events[`EV_PD_ENTER] = 1'b1;
                end
                else if (req_cmd)
                    d.state = conv_ctl_pkg::ST_TRIM;
            end
            conv_ctl_pkg::ST_TRIM:
            begin
                // Power-down is only looked at once the trim is complete
                d.trim_cnt = q.trim_cnt + 16'h1;
                if (q.trim_cnt == `TRIM_RUN_CYCLES - 16'h1)
                begin
                    events[`EV_TRIM_DONE] = 1'b1;
                    d.state = q.pd_s2 ? conv_ctl_pkg::ST_DOWN : conv_ctl_pkg::ST_RUN;
                    events[`EV_PD_ENTER] = q.pd_s2;
                end
            end
            conv_ctl_pkg::ST_DOWN:
            begin
                if (!q.pd_s2)
                    d.state = conv_ctl_pkg::ST_RUN;
            end
            default:
            begin
                d.state = conv_ctl_pkg::ST_WAIT;
            end
        endcase

        // Output enable drops while powered down or held down before power-on trim
        d.oe = !(d.state == conv_ctl_pkg::ST_DOWN
            || (d.state == conv_ctl_pkg::ST_WAIT && q.pd_s2));
        d.trim = (d.state == conv_ctl_pkg::ST_TRIM);

        // Forwarded clock divider; stopped in power-down to save power
        if (q.state != conv_ctl_pkg::ST_DOWN)
        begin
            d.div = q.div + 3'h1;
            d.fclk = d.div[2];
            launch = q.edge_s2 ? (d.div == `DIV_RISE) : (d.div == `DIV_FALL);
        end

        // Bus words change together with the selected forwarded clock edge
        if (launch)
        begin
            d.near_data = tap_near.code;
            d.near_range = tap_near.range;
            d.far_data = tap_far.code;
            d.far_range = tap_far.range;
        end

        if (sample_en && coded.range)
            events[`EV_RANGE] = 1'b1;

        // Register port: status is write-one-to-clear, a new event wins
        d.rdata = 32'h0;
        if (reg_write && reg_addr == `ADDR_MASK)
            d.mask = reg_wdata[`EV_WIDTH-1:0];
        if (reg_write && reg_addr == `ADDR_STATUS)
            d.status = q.status & ~reg_wdata[`EV_WIDTH-1:0];
        d.status = d.status | events;
        if (reg_read)
        begin
            case (reg_addr)
                `ADDR_STATUS: d.rdata = {28'h0, q.status};
                `ADDR_MASK: d.rdata = {28'h0, q.mask};
                `ADDR_STATE: d.rdata = {26'h0, q.oe, q.trim, q.state};
                default: d.rdata = 32'h0;
            endcase
        end
        d.irq = |(d.status & d.mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.state <= conv_ctl_pkg::ST_WAIT;
            {q.pd_s1, q.pd_s2, q.req_s1, q.req_s2, q.req_s3} <= 5'h1F; // Pins idle until seen
            q.status <= `STATUS_RESET;
            q.mask <= `MASK_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // Every output straight from the state register
    assign forwarded_data_clock = q.fclk;
    assign bus_near_data = q.near_data;
    assign bus_near_range = q.near_range;
    assign bus_far_data = q.far_data;
    assign bus_far_range = q.far_range;
    assign output_enable = q.oe;
    assign trim_active = q.trim;
    assign reg_rdata = q.rdata;
    assign irq = q.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_DOWN_FLOATS: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_DOWN |-> !output_enable)
        else $error("outputs driven in power-down");

    AST_PD_ENTERS: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_RUN && q.pd_s2
        |=> q.state == conv_ctl_pkg::ST_DOWN && !output_enable)
        else $error("power-down pin did not power down");

    AST_TRIM_HOLDS: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_TRIM && q.trim_cnt != `TRIM_RUN_CYCLES - 16'h1
        |=> q.state == conv_ctl_pkg::ST_TRIM)
        else $error("trim cut short");

    AST_WAIT_FROZEN: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_WAIT && q.pd_s2 && !req_cmd
        |=> $stable(q.delay_cnt) && q.state == conv_ctl_pkg::ST_WAIT)
        else $error("power-on delay ran while powered down");

    AST_DOWN_NO_TRIM: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_DOWN |=> q.state != conv_ctl_pkg::ST_TRIM
        && q.low_cnt == 4'h0)
        else $error("trim request acted on in power-down");

    AST_LAUNCH_EDGE: assert property (@(posedge clk) disable iff (rst)
        $changed(bus_near_data) |-> $changed(forwarded_data_clock)
        && forwarded_data_clock == $past(q.edge_s2))
        else $error("bus changed away from selected edge");

    AST_TRIM_FLAG: assert property (@(posedge clk) disable iff (rst)
        trim_active == (q.state == conv_ctl_pkg::ST_TRIM))
        else $error("trim active disagrees with sequencer");

    AST_REQ_SHAPE: assert property (@(posedge clk) disable iff (rst)
        req_cmd |-> $past(q.req_s2, 9) && !$past(q.req_s2, 10)
        && q.state != conv_ctl_pkg::ST_DOWN)
        else $error("trim command without ten low then ten high");

    AST_CODE_MAP: assert property (@(posedge clk) disable iff (rst)
        $signed(sample_in) == 10'sd0 |-> coded.code == 8'h80 && !coded.range)
        else $error("midscale not at 80");

    AST_CLIP_FLAG: assert property (@(posedge clk) disable iff (rst)
        $signed(sample_in) > 10'sd127 |-> coded.range && coded.code == 8'hFF)
        else $error("over-range sample not flagged");

    AST_POWER_ON: assert property (@(posedge clk) disable iff (rst)
        q.state == conv_ctl_pkg::ST_WAIT && !q.pd_s2 && delay_done && !req_cmd
        |=> q.state == conv_ctl_pkg::ST_TRIM ##1 trim_active)
        else $error("power-on trim did not start at delay end");

endmodule : conv_ctl

// >>> verif/link_receiver.sv
/*
 * Receiver model: captures both output buses mid-word, counts words that
 * move off the selected launch edge, and drives the trim request pin.
 * Assumes it shares clk with the converter block.
 */
`timescale 1ns/10ps

module link_receiver
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link driven by the converter, and the launch edge select pin
    input wire logic forwarded_data_clock,
    input wire logic [7:0] bus_near_data,
    input wire logic bus_near_range,
    input wire logic [7:0] bus_far_data,
    input wire logic bus_far_range,
    input wire logic output_enable,
    input wire logic launch_edge_select,
    // Request pin and captured words
    output logic trim_request_pin,
    output logic [8:0] near_word,
    output logic [8:0] far_word,
    output logic words_valid,
    output logic [7:0] edge_errors
);
    logic fclk_q, oe_q, moved;
    logic [17:0] bus_q, bus_now;
    logic [5:0] wake_q;

    // Words after a wake are stale until eight sample periods have passed
    assign bus_now = {bus_near_range, bus_near_data, bus_far_range, bus_far_data};
    assign moved = forwarded_data_clock != fclk_q;
    assign words_valid = output_enable && wake_q == 6'h20;

    // Pin idles high, so only a fresh low stretch can form a command
    initial trim_request_pin = 1'b1;

    task automatic command(input int low_cycles);
        @(posedge clk);
        trim_request_pin <= 1'b0;
        repeat (low_cycles) @(posedge clk);
        trim_request_pin <= 1'b1;
    endtask : command

    // Capture on the non-launch edge, where the word is settled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fclk_q <= 1'b0;
            oe_q <= 1'b0;
            bus_q <= 18'h00000;
            wake_q <= 6'h00;
            near_word <= 9'h000;
            far_word <= 9'h000;
            edge_errors <= 8'h00;
        end
        else
        begin
            fclk_q <= forwarded_data_clock;
            oe_q <= output_enable;
            bus_q <= bus_now;
            if (output_enable && oe_q && bus_now != bus_q
                && !(moved && forwarded_data_clock == launch_edge_select))
                edge_errors <= edge_errors + 8'h01;
            if (moved && forwarded_data_clock != launch_edge_select)
            begin
                near_word <= bus_now[17:9];
                far_word <= bus_now[8:0];
            end
            if (!output_enable)
                wake_q <= 6'h00;
            else if (wake_q != 6'h20)
                wake_q <= wake_q + 6'h01;
        end
    end
endmodule : link_receiver

// >>> verif/testbench.sv
/*
 * Self-checking bench of the converter control block: registers, interrupt,
 * power-down and trim sequencing, coding, latency and launch edge.
 * Assumes the power-on delays are shortened to 64 and 128 cycles.
 */
`timescale 1ns/10ps
`include "conv_ctl_defines.svh"

module testbench;
    logic clk, rst, power_down_pin, trim_request_pin, launch_edge_select;
    logic trim_delay_select, fclk, nr, fr, oe, trim_active, reg_write, reg_read;
    logic irq, words_valid, f0;
    logic [9:0] sample_in;
    logic [7:0] nd, fd, reg_addr, edge_errors, e0;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [8:0] near_word, far_word, prev, want;
    int fail_count, comparisons, n, r;
    integer seed;
    int corner [6] = '{-129, -128, -1, 0, 127, 128};

    conv_ctl #(.DELAY_SHORT(64), .DELAY_LONG(128)) conv_ctl_inst
    (
        .clk(clk), .rst(rst), .power_down_pin(power_down_pin),
        .trim_request_pin(trim_request_pin), .launch_edge_select(launch_edge_select),
        .trim_delay_select(trim_delay_select), .sample_in(sample_in),
        .forwarded_data_clock(fclk), .bus_near_data(nd), .bus_near_range(nr),
        .bus_far_data(fd), .bus_far_range(fr), .output_enable(oe),
        .trim_active(trim_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq)
    );

    link_receiver link_receiver_inst
    (
        .clk(clk), .rst(rst), .forwarded_data_clock(fclk), .bus_near_data(nd),
        .bus_near_range(nr), .bus_far_data(fd), .bus_far_range(fr),
        .output_enable(oe), .launch_edge_select(launch_edge_select),
        .trim_request_pin(trim_request_pin), .near_word(near_word),
        .far_word(far_word), .words_valid(words_valid), .edge_errors(edge_errors)
    );

    // Free-running clock, four cycles per sample
    initial
    begin
        clk = 1'b0;
        forever #(`CLK_PERIOD_NS / 2) clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic summarize();
        $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Bounded wait on the trim indicator; n counts the edges spent
    task automatic wait_for(input logic lvl, input int limit);
        n = 0;
        while (trim_active !== lvl && n < limit)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_for

    // Offset binary with clipping beyond the 8-bit span
    function automatic logic [8:0] expect_word(input logic [9:0] s);
        if ($signed(s) > 127)
            return 9'h1FF;
        if ($signed(s) < -128)
            return 9'h100;
        return {1'b0, s[7:0] ^ 8'h80};
    endfunction : expect_word

    // A hang is cut short here and counted as a mismatch
    initial
    begin
        #(20000 * `CLK_PERIOD_NS);
        check(32'h0, 32'h1);
        summarize();
    end

    // Main sequence: powered-down start, power-on trim, data, command trims
    initial
    begin
        seed = 32'h9382;
        fail_count = 0;
        comparisons = 0;
        rst = 1'b1;
        power_down_pin = 1'b1;
        launch_edge_select = 1'b0;
        trim_delay_select = 1'b0;
        sample_in = 10'h000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        prev = 9'h080;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        check(trim_active, 1'b0);
        check(oe, 1'b0);
        rd(`ADDR_STATE, rv);
        check(rv, 32'h01);
        rd(`ADDR_MASK, rv);
        check(rv, 32'h0);
        @(posedge clk);
        power_down_pin <= 1'b0;
        wait_for(1'b1, 400);
        check(n >= 64, 1'b1);
        check(n <= 68, 1'b1);
        check(trim_active, 1'b1);
        wait_for(1'b0, 2000);
        check(n, 32'h400);
        check(irq, 1'b0);
        rd(`ADDR_STATUS, rv);
        check(rv[0], 1'b1);
        wr(`ADDR_MASK, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check(irq, 1'b1);
        wr(`ADDR_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check(irq, 1'b0);
        wr(8'h0C, 32'hF);
        rd(8'h0C, rv);
        check(rv, 32'h0);
        rd(`ADDR_MASK, rv);
        check(rv, 32'h1);
        // Corner codes then random ones, under both launch edges
        for (int sel = 0; sel < 2; sel++)
        begin
            @(posedge clk);
            launch_edge_select <= sel[0];
            repeat (16) @(posedge clk);
            e0 = edge_errors;
            for (int i = 0; i < 14; i++)
            begin
                r = (i < 6) ? corner[i] : $random(seed) % 300;
                want = expect_word(r[9:0]);
                @(posedge clk);
                sample_in <= r[9:0];
                repeat (20) @(posedge clk);
                #1;
                check({nr, nd}, prev);
                repeat (40) @(posedge clk);
                #1;
                check({nr, nd}, want);
                check({fr, fd}, want);
                check(near_word, want);
                prev = want;
            end
            check(edge_errors, e0);
        end
        link_receiver_inst.command(9);
        repeat (40) @(posedge clk);
        #1;
        check(trim_active, 1'b0);
        link_receiver_inst.command(10);
        wait_for(1'b1, 40);
        check(trim_active, 1'b1);
        @(posedge clk);
        power_down_pin <= 1'b1;
        repeat (100) @(posedge clk);
        #1;
        check({trim_active, oe}, 2'h3);
        wait_for(1'b0, 1100);
        repeat (4) @(posedge clk);
        #1;
        check(oe, 1'b0);
        rd(`ADDR_STATE, rv);
        check(rv, 32'h08);
        f0 = fclk;
        repeat (24) @(posedge clk);
        #1;
        check(fclk, f0);
        link_receiver_inst.command(10);
        repeat (40) @(posedge clk);
        #1;
        check(trim_active, 1'b0);
        rd(`ADDR_STATUS, rv);
        check(rv[3:1], 3'h7);
        @(posedge clk);
        power_down_pin <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(words_valid, 1'b0);
        repeat (60) @(posedge clk);
        #1;
        check(trim_active, 1'b0);
        check(oe, 1'b1);
        check(words_valid, 1'b1);
        // Second power-on in mid-run with the long delay selected
        @(posedge clk);
        trim_delay_select <= 1'b1;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_for(1'b1, 400);
        check(trim_active, 1'b1);
        check(n >= 128, 1'b1);
        check(n <= 132, 1'b1);
        summarize();
    end
endmodule : testbench
